// [hw/rfs_switch_ctrl.sv]
// serial-bus register bank steering a dual four-throw antenna switch
`timescale 1ns/10ps
`include "rfs_params.svh"
module rfs_switch_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // serial control bus
    input wire logic sclkPin,
    input wire logic sdataIn,
    output logic sdataOut,
    output logic sdataOeN,
    // switch control
    output rfs_pkg::rfs_throws_t switchThrows,
    output logic lowPower
);
    import rfs_pkg::*;

    logic sclkLevel;
    logic sclkRise;
    logic sclkFall;
    logic sdLevel;
    logic sdRise;
    logic sdFall;
    logic sscArm;
    logic ssc;
    rfs_state_t state;
    logic [3:0] bitCnt;
    logic [12:0] shiftIn;
    logic [12:0] next_cmd;
    logic [8:0] next_data;
    logic [4:0] addr;
    logic [8:0] txShift;
    rfs_write_t wr;
    logic [7:0] shadowB;
    logic [7:0] shadowA;
    logic [7:0] pathB;
    logic [7:0] pathA;
    logic [1:0] pwrState;
    logic [2:0] trigMask;
    logic [3:0] usid;
    logic [7:0] rdData;
    logic allMasked;
    logic anyTrigger;

    rfs_sync_edge u_sclk (
        .clock(clock),
        .sys_rst(sys_rst),
        .pinIn(sclkPin),
        .level(sclkLevel),
        .rise(sclkRise),
        .fall(sclkFall)
    );

    rfs_sync_edge u_sdata (
        .clock(clock),
        .sys_rst(sys_rst),
        .pinIn(sdataIn),
        .level(sdLevel),
        .rise(sdRise),
        .fall(sdFall)
    );

    // sequence start: data pulses high and low while the clock rests low
    always_ff @(posedge clock) begin
        if (sys_rst || sclkLevel) begin
            sscArm <= 1'b0;
        end else if (sdRise && sdataOeN) begin
            sscArm <= 1'b1;
        end
    end

    assign ssc = sscArm & sdFall & ~sclkLevel & sdataOeN;
    assign next_cmd = {shiftIn[11:0], sdLevel};
    assign next_data = {shiftIn[7:0], sdLevel};

    always_comb begin
        case (addr)
            `RFS_ADDR_PATH_B: rdData = pathB;
            `RFS_ADDR_PATH_A: rdData = pathA;
            // trigger bits always read back zero
            `RFS_ADDR_PMTRIG: rdData = {pwrState, trigMask, 3'h0};
            `RFS_ADDR_PARTID: rdData = `RFS_PART_CODE;
            `RFS_ADDR_MAKER: rdData = `RFS_MAKER_CODE;
            `RFS_ADDR_USID: rdData = {2'h0, `RFS_MAKER_EXT, usid};
            default: rdData = 8'h00;
        endcase
    end

    // frame decoder and read-data driver
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= sIdle;
            bitCnt <= 4'h0;
            shiftIn <= 13'h0000;
            addr <= 5'h00;
            txShift <= 9'h000;
            wr <= '0;
            sdataOut <= 1'b0;
            sdataOeN <= 1'b1;
        end else if (ssc) begin
            state <= sCmd;
            bitCnt <= 4'h0;
            wr.strobe <= 1'b0;
        end else begin
            wr.strobe <= 1'b0;
            case (state)
                sIdle: begin
                    bitCnt <= 4'h0;
                end
                sCmd: begin
                    if (sclkFall) begin
                        shiftIn <= next_cmd;
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == `RFS_CMD_BITS - 4'h1) begin
                            bitCnt <= 4'h0;
                            state <= sIdle;
                            // odd parity and own address only
                            if ((^next_cmd) && usid ==
                                next_cmd[`RFS_SA_HI:`RFS_SA_LO]) begin
                                if (next_cmd[`RFS_OP_HI]) begin
                                    wr.strobe <= 1'b1;
                                    wr.addr <= `RFS_ADDR_PATH_B;
                                    wr.data <= {1'b0,
                                        next_cmd[`RFS_SD_HI:`RFS_RA_LO]};
                                end else if (next_cmd[`RFS_OP_HI:`RFS_OP_LO]
                                        == `RFS_CMD_WRITE) begin
                                    addr <= next_cmd[`RFS_RA_HI:`RFS_RA_LO];
                                    state <= sData;
                                end else if (next_cmd[`RFS_OP_HI:`RFS_OP_LO]
                                        == `RFS_CMD_READ) begin
                                    addr <= next_cmd[`RFS_RA_HI:`RFS_RA_LO];
                                    state <= sRdPark;
                                end
                            end
                        end
                    end
                end
                sData: begin
                    if (sclkFall) begin
                        shiftIn <= {4'h0, next_data};
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == `RFS_DATA_BITS - 4'h1) begin
                            state <= sIdle;
                            if (^next_data) begin
                                wr.strobe <= 1'b1;
                                wr.addr <= addr;
                                wr.data <= next_data[8:1];
                            end
                        end
                    end
                end
                sRdPark: begin
                    // master parks the line for one clock
                    if (sclkFall) begin
                        txShift <= {rdData, ~^rdData};
                        bitCnt <= 4'h0;
                        state <= sRdData;
                    end
                end
                sRdData: begin
                    if (sclkRise) begin
                        bitCnt <= bitCnt + 4'h1;
                        sdataOeN <= 1'b0;
                        if (bitCnt == `RFS_DATA_BITS) begin
                            sdataOut <= 1'b0;
                            state <= sRdEnd;
                        end else begin
                            sdataOut <= txShift[8];
                            txShift <= {txShift[7:0], 1'b0};
                        end
                    end
                end
                sRdEnd: begin
                    if (sclkFall) begin
                        sdataOeN <= 1'b1;
                        state <= sIdle;
                    end
                end
                default: begin
                    state <= sIdle;
                end
            endcase
        end
    end

    assign allMasked = &trigMask;
    assign anyTrigger = |(wr.data[`RFS_TRIG_HI:`RFS_TRIG_LO] & ~trigMask);

    // register bank with shadow and destination stages
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shadowB <= `RFS_PATH_RST;
            shadowA <= `RFS_PATH_RST;
            pathB <= `RFS_PATH_RST;
            pathA <= `RFS_PATH_RST;
            pwrState <= `RFS_PWR_ACTIVE;
            trigMask <= `RFS_MASK_RST;
            usid <= `RFS_USID_RST;
        end else if (wr.strobe) begin
            case (wr.addr)
                `RFS_ADDR_PATH_B: begin
                    shadowB <= wr.data;
                    if (allMasked) begin
                        pathB <= wr.data;
                    end
                end
                `RFS_ADDR_PATH_A: begin
                    shadowA <= wr.data;
                    if (allMasked) begin
                        pathA <= wr.data;
                    end
                end
                `RFS_ADDR_PMTRIG: begin
                    trigMask <= wr.data[`RFS_MASK_HI:`RFS_MASK_LO];
                    // one shared transfer for any unmasked trigger
                    if (anyTrigger) begin
                        pathB <= shadowB;
                        pathA <= shadowA;
                    end
                    case (wr.data[`RFS_PWR_HI:`RFS_PWR_LO])
                        `RFS_PWR_DEFAULTS: begin
                            shadowB <= `RFS_PATH_RST;
                            shadowA <= `RFS_PATH_RST;
                            pathB <= `RFS_PATH_RST;
                            pathA <= `RFS_PATH_RST;
                            trigMask <= `RFS_MASK_RST;
                            pwrState <= `RFS_PWR_ACTIVE;
                        end
                        `RFS_PWR_RESERVED: begin
                            pwrState <= pwrState;
                        end
                        default: begin
                            pwrState <= wr.data[`RFS_PWR_HI:`RFS_PWR_LO];
                        end
                    endcase
                end
                `RFS_ADDR_USID: begin
                    usid <= wr.data[`RFS_USID_HI:0];
                end
                default: begin
                    // part code and maker code keep their values
                    usid <= usid;
                end
            endcase
        end
    end

    function automatic logic [3:0] decodePath(input logic [4:0] code);
        logic [3:0] t;
        t = 4'h0;
        case (code)
            5'h01, 5'h0b, 5'h0f: t = 4'h1;
            5'h02, 5'h0a, 5'h0e: t = 4'h2;
            5'h03, 5'h09, 5'h0d: t = 4'h4;
            5'h04, 5'h08, 5'h0c: t = 4'h8;
            5'h10: t = 4'hc;
            5'h11: t = 4'ha;
            5'h12: t = 4'h9;
            5'h13: t = 4'h6;
            5'h14: t = 4'h5;
            5'h15: t = 4'h3;
            default: t = 4'h0;
        endcase
        return t;
    endfunction

    // throw drive; low power isolates both ports
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            switchThrows <= '0;
            lowPower <= 1'b0;
        end else begin
            lowPower <= (pwrState == `RFS_PWR_LOW);
            if (pwrState == `RFS_PWR_LOW) begin
                switchThrows <= '0;
            end else begin
                switchThrows.portOne <=
                    decodePath(pathA[`RFS_PATH_HI:0]);
                switchThrows.portTwo <=
                    decodePath(pathB[`RFS_PATH_HI:0]);
            end
        end
    end
endmodule

// [hw/rfs_sync_edge.sv]
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/10ps
module rfs_sync_edge (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // pin side
    input wire logic pinIn,
    // synchronised side
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic prev;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pinIn;
            level <= meta;
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule

// [inc/rfs_params.svh]
// constants of the antenna switch control register bank
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH

`define RFS_ADDR_PATH_B 5'h00
`define RFS_ADDR_PATH_A 5'h01
`define RFS_ADDR_PMTRIG 5'h1c
`define RFS_ADDR_PARTID 5'h1d
`define RFS_ADDR_MAKER 5'h1e
`define RFS_ADDR_USID 5'h1f

`define RFS_PATH_RST 8'h00
`define RFS_USID_RST 4'ha
`define RFS_MASK_RST 3'h0

`define RFS_PWR_ACTIVE 2'h0
`define RFS_PWR_DEFAULTS 2'h1
`define RFS_PWR_LOW 2'h2
`define RFS_PWR_RESERVED 2'h3

`define RFS_PWR_HI 7
`define RFS_PWR_LO 6
`define RFS_MASK_HI 5
`define RFS_MASK_LO 3
`define RFS_TRIG_HI 2
`define RFS_TRIG_LO 0
`define RFS_PATH_HI 4
`define RFS_USID_HI 3

// command frame fields, counted from the parity bit at position 0
`define RFS_SA_HI 12
`define RFS_SA_LO 9
`define RFS_OP_HI 8
`define RFS_OP_LO 6
`define RFS_SD_HI 7
`define RFS_RA_HI 5
`define RFS_RA_LO 1

`define RFS_CMD_BITS 4'hd
`define RFS_DATA_BITS 4'h9
`define RFS_CMD_WRITE 3'h2
`define RFS_CMD_READ 3'h3

// identification values, arbitrary
`define RFS_PART_CODE 8'h5c
`define RFS_MAKER_CODE 8'h3e
`define RFS_MAKER_EXT 2'h2

`endif

// [inc/rfs_pkg.sv]
// types shared by the antenna switch control register bank
package rfs_pkg;

    typedef enum logic [2:0] {
        sIdle,
        sCmd,
        sData,
        sRdPark,
        sRdData,
        sRdEnd
    } rfs_state_t;

    // throw enables of each antenna port, at most two set at a time
    typedef struct packed {
        logic [3:0] portOne;
        logic [3:0] portTwo;
    } rfs_throws_t;

    // register write handed from the frame decoder to the bank
    typedef struct packed {
        logic strobe;
        logic [4:0] addr;
        logic [7:0] data;
    } rfs_write_t;

endpackage

// [verif/rfs_bus_master.sv]
// serial control bus master model
`timescale 1ns/10ps
module rfs_bus_master (
    // clock
    input wire logic clock,
    // serial bus
    output logic sclkPin,
    output wire logic sdataIn,
    input wire logic sdataOut,
    input wire logic sdataOeN
);
    logic mOe = 1'b1;
    logic mDat = 1'b0;
    logic keep = 1'b1;
    initial sclkPin = 1'b0;
    // a released wire keeps the inverse of the last driven level
    assign sdataIn = !sdataOeN ? sdataOut : (mOe ? mDat : keep);
    task half;
        repeat (4) @(negedge clock);
    endtask
    task bitOut(input logic b);
        sclkPin = 1'b1;
        mDat = b;
        half;
        sclkPin = 1'b0;
        half;
    endtask
    task cmd(input logic [3:0] sa, input logic [7:0] c);
        logic [12:0] f;
        f = {sa, c, 1'b0};
        f[0] = ~^f[12:1];
        mOe = 1'b1;
        mDat = 1'b1;
        half;
        mDat = 1'b0;
        half;
        for (int i = 12; i >= 0; i--) bitOut(f[i]);
    endtask
    task wr(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d);
        cmd(sa, {3'b010, a});
        for (int i = 7; i >= 0; i--) bitOut(d[i]);
        bitOut(~^d);
        bitOut(1'b0);
        keep = ~mDat;
        mOe = 1'b0;
        half;
    endtask
    // short write: seven data bits in the command frame, then bus park
    task swr(input logic [3:0] sa, input logic [6:0] d);
        cmd(sa, {1'b1, d});
        bitOut(1'b0);
        keep = ~mDat;
        mOe = 1'b0;
        half;
    endtask
    task rd(input logic [3:0] sa, input logic [4:0] a,
            output logic [8:0] v);
        cmd(sa, {3'b011, a});
        keep = ~mDat;
        mOe = 1'b0;
        bitOut(1'b0);
        for (int i = 8; i >= 0; i--) begin
            sclkPin = 1'b1;
            half;
            sclkPin = 1'b0;
            repeat (2) @(negedge clock);
            v[i] = sdataIn;
            repeat (2) @(negedge clock);
        end
        bitOut(1'b0);
        half;
    endtask
endmodule

// [verif/rfs_switch_ctrl_sva.sv]
// port assertions of the switch control register bank
`timescale 1ns/10ps
module rfs_switch_ctrl_sva (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // serial bus
    input wire logic sclkPin,
    input wire logic sdataIn,
    input wire logic sdataOut,
    input wire logic sdataOeN,
    // switch
    input wire rfs_pkg::rfs_throws_t switchThrows,
    input wire logic lowPower
);
    import rfs_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_reset_idle: assert property ($fell(sys_rst) |-> sdataOeN &&
        !lowPower && switchThrows == '0) else $error("reset state");
    chk_low_iso: assert property (lowPower |-> switchThrows == '0)
        else $error("low power");
    chk_one_count: assert property (
        $countones(switchThrows.portOne) <= 2) else $error("port one");
    chk_two_count: assert property (
        $countones(switchThrows.portTwo) <= 2) else $error("port two");
    chk_throw_quiet: assert property (
        $changed(switchThrows) |-> sdataOeN) else $error("throws");
    chk_drive_rise: assert property ($fell(sdataOeN) |-> sclkPin)
        else $error("drive start");
    chk_drive_hold: assert property (
        $fell(sdataOeN) |=> !sdataOeN [*8]) else $error("drive hold");
    chk_park_zero: assert property (
        $rose(sdataOeN) |-> !$past(sdataOut)) else $error("bus park");
    cover property (lowPower);
    cover property ($fell(sdataOeN));
    cover property ($countones(switchThrows.portTwo) == 2);
endmodule
bind rfs_switch_ctrl rfs_switch_ctrl_sva chk_u (
    .clock(clock),
    .sys_rst(sys_rst),
    .sclkPin(sclkPin),
    .sdataIn(sdataIn),
    .sdataOut(sdataOut),
    .sdataOeN(sdataOeN),
    .switchThrows(switchThrows),
    .lowPower(lowPower)
);

// [verif/tb_top.sv]
// testbench of the switch control register bank
`timescale 1ns/10ps
`include "rfs_params.svh"
module tb_top;
    import rfs_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    wire sclkPin;
    wire sdataIn;
    logic sdataOut;
    logic sdataOeN;
    rfs_throws_t switchThrows;
    logic lowPower;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [8:0] rv;
    logic [7:0] codes [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08,
        8'h0b, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    logic [7:0] thr [14] = '{8'h1, 8'h2, 8'h4, 8'h8, 8'h0, 8'h8, 8'h1,
        8'hc, 8'ha, 8'h9, 8'h6, 8'h5, 8'h3, 8'h0};
    logic [4:0] adr [7] = '{5'h00, 5'h01, 5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h05};
    logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h00, `RFS_PART_CODE,
        `RFS_MAKER_CODE, {2'b00, `RFS_MAKER_EXT, `RFS_USID_RST}, 8'h00};
    always #10 clock = ~clock;
    rfs_switch_ctrl dut_u (
        .clock(clock),
        .sys_rst(sys_rst),
        .sclkPin(sclkPin),
        .sdataIn(sdataIn),
        .sdataOut(sdataOut),
        .sdataOeN(sdataOeN),
        .switchThrows(switchThrows),
        .lowPower(lowPower)
    );
    rfs_bus_master bus_u (
        .clock(clock),
        .sclkPin(sclkPin),
        .sdataIn(sdataIn),
        .sdataOut(sdataOut),
        .sdataOeN(sdataOeN)
    );
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        bus_u.wr(4'ha, a, d);
    endtask
    task rdc(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] e);
        bus_u.rd(sa, a, rv);
        chk("read data", rv[8:1], e);
        chk("read parity", {7'h0, ^rv}, 8'h01);
    endtask
    always @(negedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            stop_test;
        end
    end
    initial begin
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        for (int i = 0; i < 7; i++) rdc(4'ha, adr[i], rst[i]);
        $display("test reset values done");
        wr(`RFS_ADDR_PATH_A, 8'h01);
        wr(`RFS_ADDR_PATH_B, 8'h10);
        chk("port one", {4'h0, switchThrows.portOne}, 8'h00);
        wr(`RFS_ADDR_PMTRIG, 8'h08);
        wr(`RFS_ADDR_PMTRIG, 8'h09);
        chk("port one", {4'h0, switchThrows.portOne}, 8'h00);
        wr(`RFS_ADDR_PMTRIG, 8'h0c);
        chk("port one", {4'h0, switchThrows.portOne}, 8'h01);
        chk("port two", {4'h0, switchThrows.portTwo}, 8'h0c);
        rdc(4'ha, `RFS_ADDR_PMTRIG, 8'h08);
        $display("test triggers done");
        wr(`RFS_ADDR_PMTRIG, 8'h38);
        wr(`RFS_ADDR_PATH_B, 8'h15);
        chk("port two", {4'h0, switchThrows.portTwo}, 8'h03);
        for (int i = 0; i < 14; i++) begin
            wr(`RFS_ADDR_PATH_A, codes[i]);
            chk("decode", {4'h0, switchThrows.portOne}, thr[i]);
        end
        bus_u.swr(4'ha, 7'h13);
        chk("short write", {4'h0, switchThrows.portTwo}, 8'h06);
        rdc(4'ha, `RFS_ADDR_PATH_B, 8'h13);
        $display("test direct decode done");
        wr(`RFS_ADDR_PATH_A, 8'h04);
        wr(`RFS_ADDR_PMTRIG, 8'hb8);
        chk("low power", {7'h0, lowPower}, 8'h01);
        chk("port one", {4'h0, switchThrows.portOne}, 8'h00);
        wr(`RFS_ADDR_PMTRIG, 8'hf8);
        rdc(4'ha, `RFS_ADDR_PMTRIG, 8'hb8);
        wr(`RFS_ADDR_PMTRIG, 8'h38);
        chk("port one", {4'h0, switchThrows.portOne}, 8'h08);
        wr(`RFS_ADDR_PMTRIG, 8'h78);
        rdc(4'ha, `RFS_ADDR_PMTRIG, 8'h00);
        rdc(4'ha, `RFS_ADDR_PATH_A, 8'h00);
        bus_u.swr(4'ha, 7'h01);
        chk("short shadow", {4'h0, switchThrows.portTwo}, 8'h00);
        wr(`RFS_ADDR_PMTRIG, 8'h01);
        chk("port two", {4'h0, switchThrows.portTwo}, 8'h01);
        $display("test power done");
        wr(`RFS_ADDR_PARTID, 8'h00);
        rdc(4'ha, `RFS_ADDR_PARTID, `RFS_PART_CODE);
        wr(`RFS_ADDR_USID, 8'h05);
        wr(`RFS_ADDR_PMTRIG, 8'h38);
        rdc(4'h5, `RFS_ADDR_USID, {2'b00, `RFS_MAKER_EXT, 4'h5});
        rdc(4'h5, `RFS_ADDR_PMTRIG, 8'h00);
        $display("test identifiers done");
        stop_test;
    end
endmodule
